// ==== src/autobaud_map.svh ====
// Purpose: constants of the start-bit rate detector
// Assumes: 40 MHz mclk, microcode load control driven by the host
// Notes: included by bare name
// Summary of operation
// - Character sync starts on the falling edge of a start bit.
// - Time the start bit and match it against user lookup table entries.
// - Then assemble the character, compare it with two user characters.
// - On match, interrupt the host and report the entry's nominal value.
// - After a match, keep assembling and interrupting until halted.
// - Rates 150 to 115.2K bit/s recognised when table entries exist.
// - While running from RAM, block other accesses to the user RAM area.
// - Microcode runs only after enable write then processor soft reset.
`ifndef AUTOBAUD_MAP_SVH
`define AUTOBAUD_MAP_SVH
`define AB_MCLK_HZ 40000000
`define AB_MIN_RATE_BPS 150
`define AB_MAX_RATE_BPS 115200
`define AB_MAX_BIT_CYCLES (`AB_MCLK_HZ / `AB_MIN_RATE_BPS)
`define AB_CNT_W 20
`define AB_NOM_W 16
`define AB_CHAR_W 8
`define AB_ADDR_W 12
`define AB_ENABLE_OFFSET 12'h0f8
`define AB_ENABLE_VALUE 16'h0001
`define AB_USER_RAM_BYTES 576
`define AB_NOMINAL_RST 16'h0000
`endif

// ==== src/autobaud_pkg.sv ====
// Purpose: shared types of the rate detector
// Assumes: widths from autobaud_map.svh
// Notes: none
`include "autobaud_map.svh"
package autobaud_pkg;
    typedef enum {
        ST_OFF, ST_WAIT_START, ST_MEASURE, ST_CONFIRM, ST_BITS, ST_STOP,
        ST_PUSH, ST_WAIT_IDLE
    } rx_state_t;

    typedef struct packed {
        logic [`AB_CNT_W-1:0] lo_cycles;
        logic [`AB_CNT_W-1:0] hi_cycles;
        logic [`AB_NOM_W-1:0] nominal;
    } rate_entry_t;

    typedef struct packed {
        logic [`AB_NOM_W-1:0] nominal;
        logic matched;
        logic [`AB_CHAR_W-1:0] char_data;
    } rx_word_t;
endpackage

// ==== src/pair_buffer.sv ====
// Purpose: small shift buffer with valid/ready on both sides
// Assumes: head entry always sits in slot 0
// Notes: in_ready only looks at the last slot, so no comb path from out_ready
`timescale 1ns/10ps
module pair_buffer #(
    parameter int DEPTH = 2,
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [DEPTH-1:0] valid_q, valid_d;
    logic [WIDTH-1:0] data_q [DEPTH];
    logic [WIDTH-1:0] data_d [DEPTH];
    logic pop, push, placed;

    assign in_ready = ~valid_q[DEPTH-1];
    assign out_valid = valid_q[0];
    assign out_data = data_q[0];

    always_comb begin
        pop = valid_q[0] & out_ready;
        push = in_valid & ~valid_q[DEPTH-1];
        placed = 1'b0;
        valid_d = valid_q;
        for (int i = 0; i < DEPTH; i++) begin
            data_d[i] = data_q[i];
        end
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                valid_d[i] = valid_q[i+1];
                data_d[i] = data_q[i+1];
            end
            valid_d[DEPTH-1] = 1'b0;
        end
        if (push) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!valid_d[i] && !placed) begin
                    valid_d[i] = 1'b1;
                    data_d[i] = in_data;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            valid_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                data_q[i] <= '0;
            end
        end else begin
            valid_q <= valid_d;
            for (int i = 0; i < DEPTH; i++) begin
                data_q[i] <= data_d[i];
            end
        end
    end
endmodule

// ==== src/autobaud_rate_detector.sv ====
// Purpose: start-bit rate detector with character match and stream out
// Assumes: rxd idles high, 8N1-like frames, lookup table held by host
// Notes: line is ignored while a word waits for buffer room
`timescale 1ns/10ps
`include "autobaud_map.svh"
module autobaud_rate_detector #(
    parameter int N_RATES = 14,
    parameter int CHAR_BITS = `AB_CHAR_W,
    parameter int MAX_BIT_CYCLES = `AB_MAX_BIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Serial line
    input wire logic rxd,
    // Host control
    input wire logic rx_run,
    input wire logic cfg_wr,
    input wire logic cfg_super,
    input wire logic [`AB_ADDR_W-1:0] cfg_addr,
    input wire logic [`AB_NOM_W-1:0] cfg_data,
    input wire logic cmd_soft_reset,
    // User RAM arbitration
    input wire logic dpram_req,
    output logic dpram_grant,
    // Lookup table and match characters
    input wire autobaud_pkg::rate_entry_t [N_RATES-1:0] rate_table,
    input wire logic [`AB_CHAR_W-1:0] match_char_a,
    input wire logic [`AB_CHAR_W-1:0] match_char_b,
    // Character stream
    output logic out_valid,
    input wire logic out_ready,
    output autobaud_pkg::rx_word_t out_word,
    // Status
    output logic irq,
    output logic [`AB_NOM_W-1:0] nominal_value,
    output logic rate_locked,
    output logic ucode_running
);
    import autobaud_pkg::*;

    localparam logic [`AB_CNT_W-1:0] MAX_CNT = `AB_CNT_W'(MAX_BIT_CYCLES);
    localparam logic [3:0] LAST_BIT = 4'(CHAR_BITS - 1);

    // Line synchroniser, first stage read only by the second
    logic rx_meta_q, rx_sync_q, rx_prev_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            rx_meta_q <= rxd;
            rx_sync_q <= rx_meta_q;
            rx_prev_q <= rx_sync_q;
        end
    end

    // Microcode enable and run state
    logic armed_q, armed_d, run_q, run_d, grant_q, grant_d;
    always_comb begin
        armed_d = armed_q;
        run_d = run_q;
        if (cfg_wr && cfg_super && cfg_addr == `AB_ENABLE_OFFSET) begin
            armed_d = (cfg_data == `AB_ENABLE_VALUE);
        end
        // Soft reset picks up whatever enable value is in place
        if (cmd_soft_reset) begin
            run_d = armed_d;
        end
        grant_d = dpram_req & ~run_d;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
            run_q <= 1'b0;
            grant_q <= 1'b0;
        end else begin
            armed_q <= armed_d;
            run_q <= run_d;
            grant_q <= grant_d;
        end
    end
    assign dpram_grant = grant_q;
    assign ucode_running = run_q;

    // Table compare, one comparator pair per entry
    logic [`AB_CNT_W-1:0] cnt_q, cnt_d;
    logic [N_RATES-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < N_RATES; g++) begin : g_rate
            assign hit[g] = cnt_q >= rate_table[g].lo_cycles &&
                            cnt_q <= rate_table[g].hi_cycles;
        end
    endgenerate

    logic any_hit;
    logic [`AB_NOM_W-1:0] hit_nom;
    always_comb begin
        any_hit = 1'b0;
        hit_nom = '0;
        // Lowest index wins when entries overlap
        for (int i = N_RATES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                any_hit = 1'b1;
                hit_nom = rate_table[i].nominal;
            end
        end
    end

    // Receive state
    rx_state_t st_q, st_d;
    logic [`AB_CNT_W-1:0] period_q, period_d;
    logic [`AB_NOM_W-1:0] cand_q, cand_d, nom_q, nom_d;
    logic [`AB_CHAR_W-1:0] shift_q, shift_d;
    logic [3:0] bit_q, bit_d;
    logic locked_q, locked_d, irq_q, irq_d, match_q, match_d;
    logic push_valid, push_ready, active, fall, char_hit;
    rx_word_t push_word;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        period_d = period_q;
        cand_d = cand_q;
        nom_d = nom_q;
        shift_d = shift_q;
        bit_d = bit_q;
        locked_d = locked_q;
        match_d = match_q;
        irq_d = 1'b0;
        push_valid = 1'b0;
        active = rx_run & run_q;
        fall = rx_prev_q & ~rx_sync_q;
        char_hit = shift_q == match_char_a || shift_q == match_char_b;
        push_word.nominal = cand_q;
        push_word.matched = match_q;
        push_word.char_data = shift_q;
        case (st_q)
            ST_OFF: begin
                if (active) begin
                    st_d = ST_WAIT_IDLE;
                end
            end
            ST_WAIT_IDLE: begin
                if (rx_sync_q) begin
                    st_d = ST_WAIT_START;
                end
            end
            ST_WAIT_START: begin
                if (fall) begin
                    cnt_d = '0;
                    if (locked_q) begin
                        cnt_d = period_q >> 1;
                        st_d = ST_CONFIRM;
                    end else begin
                        st_d = ST_MEASURE;
                    end
                end
            end
            ST_MEASURE: begin
                if (rx_sync_q) begin
                    // Start bit over; its length picks the table entry
                    if (any_hit) begin
                        period_d = cnt_q;
                        cand_d = hit_nom;
                        cnt_d = cnt_q >> 1;
                        bit_d = '0;
                        st_d = ST_BITS;
                    end else begin
                        st_d = ST_WAIT_START;
                    end
                end else if (cnt_q >= MAX_CNT) begin
                    st_d = ST_WAIT_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_CONFIRM: begin
                if (cnt_q <= 1) begin
                    // Glitch shorter than half a bit is not a start
                    if (rx_sync_q) begin
                        st_d = ST_WAIT_START;
                    end else begin
                        cnt_d = period_q;
                        bit_d = '0;
                        st_d = ST_BITS;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_BITS: begin
                if (cnt_q <= 1) begin
                    // LSB first, mid-bit sample
                    shift_d = shift_q >> 1;
                    shift_d[`AB_CHAR_W-1] = rx_sync_q;
                    cnt_d = period_q;
                    bit_d = bit_q + 1'b1;
                    if (bit_q == LAST_BIT) begin
                        st_d = ST_STOP;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_STOP: begin
                if (cnt_q <= 1) begin
                    match_d = char_hit;
                    if (rx_sync_q && (locked_q || char_hit)) begin
                        st_d = ST_PUSH;
                    end else begin
                        st_d = ST_WAIT_IDLE;
                    end
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_PUSH: begin
                push_valid = 1'b1;
                if (push_ready) begin
                    if (!locked_q) begin
                        nom_d = cand_q;
                    end
                    locked_d = 1'b1;
                    irq_d = 1'b1;
                    st_d = ST_WAIT_START;
                end
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        // Halt wins over state, lock, irq and push; timing value is left as it was
        if (!active) begin
            st_d = ST_OFF;
            locked_d = 1'b0;
            irq_d = 1'b0;
            push_valid = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_q <= ST_OFF;
            cnt_q <= '0;
            period_q <= '0;
            cand_q <= '0;
            nom_q <= `AB_NOMINAL_RST;
            shift_q <= '0;
            bit_q <= '0;
            locked_q <= 1'b0;
            match_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            period_q <= period_d;
            cand_q <= cand_d;
            nom_q <= nom_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            locked_q <= locked_d;
            match_q <= match_d;
            irq_q <= irq_d;
        end
    end
    assign irq = irq_q;
    assign nominal_value = nom_q;
    assign rate_locked = locked_q;

    // Two entries ride out a short stall of the reader
    pair_buffer #(
        .DEPTH(2),
        .WIDTH($bits(rx_word_t))
    ) u_buf (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_word)
    );
endmodule

// ==== testbench/autobaud_monitor.sv ====
// Purpose: port checker of the start-bit rate detector
// Assumes: one clock, sync active-high reset
// Notes: bound onto every detector instance
`timescale 1ns/10ps
module autobaud_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Host side
    input wire logic rx_run,
    input wire logic cmd_soft_reset,
    input wire logic dpram_req,
    input wire logic dpram_grant,
    // Stream and status
    input wire logic out_valid,
    input wire logic out_ready,
    input wire autobaud_pkg::rx_word_t out_word,
    input wire logic irq,
    input wire logic [15:0] nominal_value,
    input wire logic rate_locked,
    input wire logic ucode_running
);
    import autobaud_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Three low samples so a push already in flight is not flagged
    sequence s_halted;
        !rx_run ##1 !rx_run ##1 !rx_run;
    endsequence
    property p_lockout;
        ucode_running |=> !dpram_grant;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("grant while running");
    property p_grant;
        // Grant drops in the same cycle that running rises
        !$past(sys_rst) |->
            dpram_grant == ($past(dpram_req) && !ucode_running);
    endproperty
    a_grant: assert property (p_grant)
        else $error("grant mismatch");
    property p_run_cause;
        $rose(ucode_running) |-> $past(cmd_soft_reset);
    endproperty
    a_run_cause: assert property (p_run_cause)
        else $error("run without soft reset");
    property p_run_hold;
        !$past(cmd_soft_reset) |-> $stable(ucode_running);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("run changed alone");
    property p_irq_pulse;
        irq |=> !irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq too long");
    property p_irq_valid;
        irq |-> out_valid;
    endproperty
    a_irq_valid: assert property (p_irq_valid)
        else $error("irq without word");
    property p_halt_quiet;
        s_halted |-> !irq && !rate_locked && $stable(nominal_value);
    endproperty
    a_halt_quiet: assert property (p_halt_quiet)
        else $error("activity while halted");
    property p_out_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_word);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("word lost under stall");
endmodule

bind autobaud_rate_detector autobaud_monitor i_autobaud_monitor (
    .mclk(mclk), .sys_rst(sys_rst), .rx_run(rx_run),
    .cmd_soft_reset(cmd_soft_reset), .dpram_req(dpram_req),
    .dpram_grant(dpram_grant), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word), .irq(irq),
    .nominal_value(nominal_value), .rate_locked(rate_locked),
    .ucode_running(ucode_running));

// ==== testbench/line_sender.sv ====
// Purpose: terminal sending async characters on rxd
// Assumes: period given in mclk cycles
// Notes: line idles high between frames
`timescale 1ns/10ps
module line_sender (
    // Clock
    input wire logic mclk,
    // Serial line
    output logic rxd
);
    initial rxd = 1'b1;
    // Low start, 8 data LSB first, high stop
    task automatic send(input logic [7:0] ch, input int per);
        logic [9:0] frame;
        frame = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd = frame[i];
            repeat (per) @(negedge mclk);
        end
    endtask
endmodule

// ==== testbench/tb.sv ====
// Purpose: self-checking bench of the rate detector
// Assumes: 40 MHz mclk, short max bit count
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module tb;
    import autobaud_pkg::*;
    logic mclk, sys_rst, rxd, rx_run, cfg_wr, cfg_super, cmd_soft_reset;
    logic dpram_req, dpram_grant, out_valid, out_ready, irq;
    logic rate_locked, ucode_running;
    logic [11:0] cfg_addr;
    logic [15:0] cfg_data, nominal_value;
    rate_entry_t [1:0] tbl;
    rx_word_t out_word;
    int fails = 0, n_checks = 0, irqs = 0, cyc = 0;

    autobaud_rate_detector #(.N_RATES(2), .MAX_BIT_CYCLES(2000))
    i_autobaud_rate_detector (
        .mclk(mclk), .sys_rst(sys_rst), .rxd(rxd), .rx_run(rx_run),
        .cfg_wr(cfg_wr), .cfg_super(cfg_super), .cfg_addr(cfg_addr),
        .cfg_data(cfg_data), .cmd_soft_reset(cmd_soft_reset),
        .dpram_req(dpram_req), .dpram_grant(dpram_grant),
        .rate_table(tbl), .match_char_a(8'h41), .match_char_b(8'h0d),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word),
        .irq(irq), .nominal_value(nominal_value),
        .rate_locked(rate_locked), .ucode_running(ucode_running));
    line_sender i_line_sender (.mclk(mclk), .rxd(rxd));

    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (irq === 1'b1) irqs++;
        cyc++;
        // Whole run needs about 6100 cycles
        if (cyc == 30000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize;
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask
    task automatic arm(input logic s, input logic [11:0] a,
                       input logic [15:0] d, input logic exp);
        @(negedge mclk);
        {cfg_wr, cfg_super, cfg_addr, cfg_data} = {1'b1, s, a, d};
        @(negedge mclk);
        cfg_wr = 1'b0;
        cmd_soft_reset = 1'b1;
        @(negedge mclk);
        cmd_soft_reset = 1'b0;
        repeat (2) @(negedge mclk);
        chk(ucode_running === exp, "microcode enable");
        chk(dpram_grant === !exp, "user ram lockout");
    endtask
    task automatic pop(input logic [7:0] c, input logic m,
                       input logic [15:0] n);
        for (int i = 0; i < 20 && out_valid !== 1'b1; i++) @(negedge mclk);
        chk(out_word.char_data === c && out_word.matched === m, "word");
        chk(out_valid === 1'b1 && out_word.nominal === n, "word nominal");
        out_ready = 1'b1;
        @(negedge mclk);
        out_ready = 1'b0;
    endtask

    task automatic t_reset;
        chk(out_valid === 1'b0 && irq === 1'b0, "reset stream");
        chk(nominal_value === 16'h0000 && rate_locked === 1'b0, "reset rate");
        chk(ucode_running === 1'b0, "reset run");
    endtask
    task automatic t_enable;
        arm(1'b0, 12'h0f8, 16'h0001, 1'b0);
        arm(1'b1, 12'h0f4, 16'h0001, 1'b0);
        arm(1'b1, 12'h0f8, 16'h0002, 1'b0);
        arm(1'b1, 12'h0f8, 16'h0001, 1'b1);
    endtask
    task automatic t_hunt;
        rx_run = 1'b1;
        i_line_sender.send(8'h41, 80);
        repeat (100) @(negedge mclk);
        chk(irqs === 1 && rate_locked === 1'b1, "hunt match");
        // Host would program the channel rate from this value
        chk(nominal_value === 16'h0050, "nominal");
        pop(8'h41, 1'b1, 16'h0050);
    endtask
    task automatic t_stream;
        logic [7:0] ch[4] = '{8'h42, 8'h0d, 8'h33, 8'h44};
        // Mixed parity; reader stalls so the fourth is lost on the line
        foreach (ch[i]) i_line_sender.send(ch[i], 80);
        repeat (100) @(negedge mclk);
        chk(irqs === 3, "full buffer holds two");
        pop(8'h42, 1'b0, 16'h0050);
        pop(8'h0d, 1'b1, 16'h0050);
        pop(8'h33, 1'b0, 16'h0050);
        chk(irqs === 4 && out_valid === 1'b0, "drained");
    endtask
    task automatic t_halt;
        rx_run = 1'b0;
        @(negedge mclk);
        i_line_sender.send(8'h41, 40);
        repeat (20) @(negedge mclk);
        chk(irqs === 4 && rate_locked === 1'b0, "halted");
        chk(nominal_value === 16'h0050, "value kept");
        rx_run = 1'b1;
        // Known rate but no match, then a start length missing from the table
        i_line_sender.send(8'h55, 40);
        i_line_sender.send(8'h41, 60);
        repeat (20) @(negedge mclk);
        chk(irqs === 4 && rate_locked === 1'b0, "no match");
        chk(nominal_value === 16'h0050, "value still kept");
        i_line_sender.send(8'h41, 40);
        repeat (20) @(negedge mclk);
        chk(nominal_value === 16'h0028 && irqs === 5, "rehunt");
        pop(8'h41, 1'b1, 16'h0028);
    endtask

    initial begin
        sys_rst = 1'b1;
        {rx_run, cfg_wr, cfg_super, cmd_soft_reset, out_ready} = 5'h00;
        {cfg_addr, cfg_data} = 28'h0000000;
        dpram_req = 1'b1;
        tbl[0] = '{20'h0001e, 20'h00032, 16'h0028};
        tbl[1] = '{20'h00046, 20'h0005a, 16'h0050};
        repeat (6) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_enable();
        t_hunt();
        t_stream();
        t_halt();
        summarize();
    end
endmodule
